/* rtl/fbp_host.sv */
// host controller that drives the block-protection command sets of a parallel NOR flash
// assumes the flash sits directly on the pins and software uses the register port
//
// Overview of operation
// - x8 password read takes eight reads, addresses 00 to 07, bytes in order.
// - x8 unlock is eleven writes; cycles five to ten carry positions 02 to 07.
// - x16 unlock is seven writes; cycles five and six carry positions 02 and 03.
// - lock register program or readback only after entering set 40h; the host accepts OP_READ in any mode, read mode included.
// - password program A0h, after entering set 60h, stores one password portion.
// - whole password program repeats eight times in x8, four in x16.
// - password verify reads eight consecutive positions in x8, four in x16.
// - unlock commands must be spaced at least 1 us apart.
// - allow 1 us after an accepted unlock before relying on it.
// - in set C0h, program A0h with block address protects that block.
// - in set 50h, program A0h sets the global lock; reads return it.
// - in set E0h, program A0h protects one block's volatile bit; reads return it.
// - leave any protection set with exit sequence 90h/00h.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module fbp_host (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// flash pins
	output logic [23:0] flash_addr_out,
	input wire logic [15:0] flash_dq_in,
	output logic [15:0] flash_dq_out,
	output logic [15:0] flash_dq_oe_out,
	output logic flash_ce_n_out,
	output logic flash_oe_n_out,
	output logic flash_we_n_out,
	output logic flash_byte_n_out
);
	import fbp_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		fbp_seq_t st;
		fbp_mode_t mode;
		logic [3:0] op;
		logic [7:0] code;
		logic [4:0] idx;
		logic byte_n;
		logic [24:0] addr;
		logic [15:0] wdata;
		logic [63:0] pwd;
		logic [63:0] pwrd;
		logic [15:0] rd;
		logic err;
		logic start;
		logic settle;
		logic [31:0] rdata;
	} fbp_ctl_t;
	fbp_ctl_t st_reg, st_next;
	fbp_step_t cur;
	logic cyc_done;
	logic [15:0] cyc_rdata;
	logic dly_busy;
	logic busy;
	logic cmd_ok;
	logic [3:0] cmd_op;
	logic [7:0] cmd_code;
	logic [31:0] stat;

	// ------------------------------------------------------------
	// command helpers
	// ------------------------------------------------------------
	function automatic fbp_mode_t mode_of(input logic [7:0] code);
		case (code)
			CODE_LOCKREG: return MODE_LOCKREG;
			CODE_PASSWORD: return MODE_PASSWORD;
			CODE_NVPB: return MODE_NVPB;
			CODE_LOCKBIT: return MODE_LOCKBIT;
			CODE_VPB: return MODE_VPB;
			CODE_EXT: return MODE_EXT;
			default: return MODE_READ;
		endcase
	endfunction

	// a set must be entered from read mode and left before another is entered
	function automatic logic legal(input logic [3:0] op, input logic [7:0] code,
		input fbp_mode_t mode);
		case (op)
			OP_ENTER: return mode == MODE_READ && mode_of(code) != MODE_READ;
			OP_EXIT_PROT: return mode != MODE_READ && mode != MODE_EXT;
			OP_EXIT_EXT: return mode == MODE_EXT;
			OP_PROG: return mode != MODE_READ && mode != MODE_EXT;
			OP_READ: return 1'b1;
			OP_CLR_NV: return mode == MODE_NVPB;
			OP_UNLOCK: return mode == MODE_PASSWORD;
			OP_PW_PROG: return mode == MODE_PASSWORD;
			OP_PW_READ: return mode == MODE_PASSWORD;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] pw_part(input logic [63:0] pwd, input logic [4:0] pos,
		input logic bm);
		return bm ? {8'h00, pwd[{pos[2:0], 3'b000} +: 8]} : pwd[{pos[1:0], 4'h0} +: 16];
	endfunction

	// one bus cycle of an operation, selected by its step index
	function automatic fbp_step_t step_of(input fbp_ctl_t s);
		fbp_step_t r;
		logic bm;
		logic [24:0] c1;
		logic [24:0] c2;
		logic [4:0] n;
		logic [4:0] pos;
		bm = !s.byte_n;
		c1 = bm ? A_X8_1 : A_X16_1;
		c2 = bm ? A_X8_2 : A_X16_2;
		n = bm ? PW_N_X8 : PW_N_X16;
		pos = 5'h00;
		r = '{wr: 1'b1, last: 1'b0, a: A_ZERO, d: {8'h00, D_ZERO}};
		case (s.op)
			OP_ENTER: begin
				r.a = (s.idx == 5'h01) ? c2 : c1;
				r.d[7:0] = (s.idx == 5'h00) ? D_UNLK1 : (s.idx == 5'h01) ? D_UNLK2 : s.code;
				r.last = s.idx == 5'h02;
			end
			OP_EXIT_PROT: begin
				r.d[7:0] = (s.idx == 5'h00) ? D_EXIT : D_ZERO;
				r.last = s.idx == 5'h01;
			end
			OP_EXIT_EXT: begin
				r.a = (s.idx == 5'h01) ? c2 : (s.idx == 5'h03) ? A_ZERO : c1;
				r.d[7:0] = (s.idx == 5'h00) ? D_UNLK1 : (s.idx == 5'h01) ? D_UNLK2 :
					(s.idx == 5'h02) ? D_EXIT : D_ZERO;
				r.last = s.idx == 5'h03;
			end
			OP_PROG: begin
				r.a = (s.idx == 5'h00) ? A_ZERO : s.addr;
				r.d = (s.idx == 5'h00) ? {8'h00, D_PROG} : s.wdata;
				r.last = s.idx == 5'h01;
			end
			OP_READ: begin
				r.wr = 1'b0;
				r.a = s.addr;
				r.last = 1'b1;
			end
			OP_CLR_NV: begin
				r.d[7:0] = (s.idx == 5'h00) ? D_CLR1 : D_CLR2;
				r.last = s.idx == 5'h01;
			end
			OP_UNLOCK: begin
				pos = 5'(s.idx - 5'h02);
				if (s.idx == 5'h00) begin
					r.d[7:0] = D_PW1;
				end else if (s.idx == 5'h01) begin
					r.d[7:0] = D_PW2;
				end else if (pos < n) begin
					r.a = {20'h00000, pos};
					r.d = pw_part(s.pwd, pos, bm);
				end else begin
					r.d[7:0] = D_PWEND;
					r.last = 1'b1;
				end
			end
			OP_PW_PROG: begin
				pos = {1'b0, s.idx[4:1]};
				r.a = s.idx[0] ? {20'h00000, pos} : A_ZERO;
				r.d = s.idx[0] ? pw_part(s.pwd, pos, bm) : {8'h00, D_PROG};
				r.last = s.idx == 5'((n << 1) - 5'h01);
			end
			OP_PW_READ: begin
				r.wr = 1'b0;
				r.a = {20'h00000, s.idx};
				r.last = s.idx == 5'(n - 5'h01);
			end
			default: begin
				r.last = 1'b1;
			end
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		cur = step_of(st_reg);
		busy = st_reg.st != S_IDLE;
		cmd_op = reg_wdata_in[CMD_OP_LSB +: 4];
		cmd_code = reg_wdata_in[CMD_CODE_LSB +: 8];
		cmd_ok = legal(cmd_op, cmd_code, st_reg.mode);
		stat = 32'h00000000;
		stat[ST_BUSY] = busy;
		stat[ST_ERR] = st_reg.err;
		stat[ST_PROT] = st_reg.rd[7:0] == STAT_PROTECTED;
		stat[ST_MODE_LSB +: 3] = st_reg.mode;
	end

	always_comb begin
		st_next = st_reg;
		st_next.start = 1'b0;
		st_next.settle = 1'b0;
		st_next.rdata = 32'h00000000;
		if (reg_wr_in) begin
			if (reg_addr_in == REG_STATUS) begin
				if (reg_wdata_in[ST_ERR]) begin
					st_next.err = 1'b0;
				end
			end else if (busy) begin
				// changing operands mid-sequence would corrupt the bus cycles
				st_next.err = 1'b1;
			end else begin
				case (reg_addr_in)
					REG_CMD: begin
						if (!cmd_ok) begin
							st_next.err = 1'b1;
						end else begin
							st_next.st = S_ISSUE;
							st_next.op = cmd_op;
							st_next.code = cmd_code;
							st_next.idx = 5'h00;
							if (cmd_op == OP_ENTER) begin
								st_next.mode = mode_of(cmd_code);
							end else if (cmd_op == OP_EXIT_PROT || cmd_op == OP_EXIT_EXT) begin
								st_next.mode = MODE_READ;
							end
						end
					end
					REG_CFG: st_next.byte_n = !reg_wdata_in[CFG_BYTE_BIT];
					REG_ADDR: st_next.addr = reg_wdata_in[24:0];
					REG_WDATA: st_next.wdata = reg_wdata_in[15:0];
					REG_PWD_LO: st_next.pwd[31:0] = reg_wdata_in;
					REG_PWD_HI: st_next.pwd[63:32] = reg_wdata_in;
					default: st_next.err = st_reg.err;
				endcase
			end
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				REG_CFG: st_next.rdata = 32'(!st_reg.byte_n);
				REG_ADDR: st_next.rdata = 32'(st_reg.addr);
				REG_WDATA: st_next.rdata = 32'(st_reg.wdata);
				REG_PWD_LO: st_next.rdata = st_reg.pwd[31:0];
				REG_PWD_HI: st_next.rdata = st_reg.pwd[63:32];
				REG_STATUS: st_next.rdata = stat;
				REG_RDATA: st_next.rdata = 32'(st_reg.rd);
				REG_PWRD_LO: st_next.rdata = st_reg.pwrd[31:0];
				REG_PWRD_HI: st_next.rdata = st_reg.pwrd[63:32];
				default: st_next.rdata = 32'h00000000;
			endcase
		end
		case (st_reg.st)
			S_IDLE: begin
				st_next.idx = st_next.idx;
			end
			S_ISSUE: begin
				st_next.start = 1'b1;
				st_next.st = S_WAIT;
			end
			S_WAIT: begin
				if (cyc_done) begin
					if (!cur.wr && st_reg.op == OP_PW_READ) begin
						if (st_reg.byte_n) begin
							st_next.pwrd[{st_reg.idx[1:0], 4'h0} +: 16] = cyc_rdata;
						end else begin
							st_next.pwrd[{st_reg.idx[2:0], 3'b000} +: 8] = cyc_rdata[7:0];
						end
					end else if (!cur.wr) begin
						st_next.rd = st_reg.byte_n ? cyc_rdata : {8'h00, cyc_rdata[7:0]};
					end
					if (!cur.last) begin
						st_next.idx = st_reg.idx + 5'h01;
						st_next.st = S_ISSUE;
					end else if (st_reg.op == OP_UNLOCK) begin
						st_next.settle = 1'b1;
						st_next.st = S_SETTLE;
					end else begin
						st_next.st = S_IDLE;
					end
				end
			end
			S_SETTLE: begin
				if (!st_reg.settle && !dly_busy) begin
					st_next.st = S_IDLE;
				end
			end
			default: begin
				st_next.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
			st_reg.byte_n <= 1'b1;
			st_reg.pwd <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// bus cycle engine and unlock guard
	// ------------------------------------------------------------
	fbp_bus_cycle u_cycle (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.start_in(st_reg.start),
		.wr_in(cur.wr),
		.byte_mode_in(!st_reg.byte_n),
		.a_in(cur.a),
		.d_in(cur.d),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata),
		.addr_out(flash_addr_out),
		.dq_in(flash_dq_in),
		.dq_out(flash_dq_out),
		.dq_oe_out(flash_dq_oe_out),
		.ce_n_out(flash_ce_n_out),
		.oe_n_out(flash_oe_n_out),
		.we_n_out(flash_we_n_out)
	);

	fbp_delay u_delay (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.load_in(st_reg.settle),
		.busy_out(dly_busy)
	);

	assign reg_rdata_out = st_reg.rdata;
	assign flash_byte_n_out = st_reg.byte_n;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [4:0] a_ncyc;
	logic [7:0] a_gap;
	logic a_end;
	assign a_end = cyc_done && st_reg.st == S_WAIT && cur.last;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || st_reg.st == S_IDLE) begin
			a_ncyc <= 5'h00;
		end else if (cyc_done) begin
			a_ncyc <= a_ncyc + 5'h01;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			a_gap <= 8'hff;
		end else if (a_end && st_reg.op == OP_UNLOCK) begin
			a_gap <= 8'h00;
		end else if (a_gap != 8'hff) begin
			a_gap <= a_gap + 8'h01;
		end
	end

	sequence s_unlock_end;
		a_end && st_reg.op == OP_UNLOCK;
	endsequence
	sequence s_settle_hold;
		(st_reg.st == S_SETTLE && busy)[*8];
	endsequence

	property p_pwread_x8;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(a_end && st_reg.op == OP_PW_READ && !st_reg.byte_n) |-> a_ncyc == PW_N_X8 - 5'h01;
	endproperty
	a_pwread_x8: assert property (p_pwread_x8) else $error("x8 password read length wrong");
	property p_unlock_x8;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(s_unlock_end and !st_reg.byte_n) |-> a_ncyc == PW_N_X8 + 5'h02;
	endproperty
	a_unlock_x8: assert property (p_unlock_x8) else $error("x8 unlock length wrong");
	property p_unlock_x16;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(s_unlock_end and st_reg.byte_n) |-> a_ncyc == PW_N_X16 + 5'h02;
	endproperty
	a_unlock_x16: assert property (p_unlock_x16) else $error("x16 unlock length wrong");
	property p_enter_first;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(st_reg.start && st_reg.op == OP_PROG) |-> st_reg.mode != MODE_READ;
	endproperty
	a_enter_first: assert property (p_enter_first) else $error("program outside a set");
	property p_pw_prog_code;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(st_reg.start && st_reg.op == OP_PW_PROG && !st_reg.idx[0]) |->
			cur.d[7:0] == D_PROG && st_reg.mode == MODE_PASSWORD;
	endproperty
	a_pw_prog_code: assert property (p_pw_prog_code) else $error("bad password program");
	property p_pwprog_x8;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(a_end && st_reg.op == OP_PW_PROG && !st_reg.byte_n) |->
			a_ncyc == (PW_N_X8 << 1) - 5'h01;
	endproperty
	a_pwprog_x8: assert property (p_pwprog_x8) else $error("x8 password program count");
	property p_pwread_x16;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(a_end && st_reg.op == OP_PW_READ && st_reg.byte_n) |-> a_ncyc == PW_N_X16 - 5'h01;
	endproperty
	a_pwread_x16: assert property (p_pwread_x16) else $error("x16 password read count");
	property p_spacing;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(st_reg.start && st_reg.op == OP_UNLOCK && st_reg.idx == 5'h00) |-> a_gap >= UNLOCK_CYC;
	endproperty
	a_spacing: assert property (p_spacing) else $error("unlock spacing too short");
	property p_settle;
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_unlock_end |=> s_settle_hold;
	endproperty
	a_settle: assert property (p_settle) else $error("unlock settle cut short");
	property p_exit;
		@(posedge mclk_in) disable iff (!rst_n_in)
		(a_end && st_reg.op == OP_EXIT_PROT) |-> cur.d[7:0] == D_ZERO ##1
			(st_reg.st == S_IDLE && st_reg.mode == MODE_READ);
	endproperty
	a_exit: assert property (p_exit) else $error("exit did not return to read");
endmodule

/* rtl/fbp_pkg.sv */
// constants and types shared by the flash block-protection host controller
// assumes a 100 MHz clock and a parallel NOR flash put in x8 or x16 bus mode by the host through flash_byte_n_out
package fbp_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_AS_NS = 10;
	localparam int T_WP_NS = 40;
	localparam int T_ACC_NS = 80;
	localparam int T_REC_NS = 30;
	localparam int T_UNLOCK_NS = 1000;
	localparam int AS_CYC = (T_AS_NS * CLK_MHZ + 999) / 1000;
	localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;
	localparam int UNLOCK_CYC = (T_UNLOCK_NS * CLK_MHZ + 999) / 1000;

	// ------------------------------------------------------------
	// register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00, REG_CFG = 8'h04, REG_ADDR = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0c, REG_PWD_LO = 8'h10, REG_PWD_HI = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18, REG_RDATA = 8'h1c;
	localparam logic [7:0] REG_PWRD_LO = 8'h20, REG_PWRD_HI = 8'h24;
	localparam int CMD_OP_LSB = 0, CMD_CODE_LSB = 4, CFG_BYTE_BIT = 0;
	localparam int ST_BUSY = 0, ST_ERR = 1, ST_PROT = 2, ST_MODE_LSB = 4;

	// ------------------------------------------------------------
	// operations and bus codes
	// ------------------------------------------------------------
	localparam logic [3:0] OP_ENTER = 4'h0, OP_EXIT_PROT = 4'h1, OP_EXIT_EXT = 4'h2;
	localparam logic [3:0] OP_PROG = 4'h3, OP_READ = 4'h4, OP_CLR_NV = 4'h5;
	localparam logic [3:0] OP_UNLOCK = 4'h6, OP_PW_PROG = 4'h7, OP_PW_READ = 4'h8;
	localparam logic [7:0] CODE_LOCKREG = 8'h40, CODE_PASSWORD = 8'h60, CODE_NVPB = 8'hc0;
	localparam logic [7:0] CODE_LOCKBIT = 8'h50, CODE_VPB = 8'he0, CODE_EXT = 8'h88;
	localparam logic [7:0] D_UNLK1 = 8'haa, D_UNLK2 = 8'h55, D_PROG = 8'ha0, D_EXIT = 8'h90;
	localparam logic [7:0] D_ZERO = 8'h00, D_CLR1 = 8'h80, D_CLR2 = 8'h30;
	localparam logic [7:0] D_PW1 = 8'h25, D_PW2 = 8'h03, D_PWEND = 8'h29;
	localparam logic [7:0] STAT_PROTECTED = 8'h00;
	localparam logic [24:0] A_X8_1 = 25'h0000aaa, A_X8_2 = 25'h0000555;
	localparam logic [24:0] A_X16_1 = 25'h0000555, A_X16_2 = 25'h00002aa, A_ZERO = 25'h0000000;
	localparam logic [4:0] PW_N_X8 = 5'h08, PW_N_X16 = 5'h04;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_READ = 3'h0, MODE_LOCKREG = 3'h1, MODE_PASSWORD = 3'h2, MODE_NVPB = 3'h3,
		MODE_LOCKBIT = 3'h4, MODE_VPB = 3'h5, MODE_EXT = 3'h6
	} fbp_mode_t;
	typedef enum logic [1:0] {S_IDLE = 2'h0, S_ISSUE = 2'h1, S_WAIT = 2'h3, S_SETTLE = 2'h2} fbp_seq_t;
	typedef enum logic [1:0] {C_IDLE = 2'h0, C_SETUP = 2'h1, C_STROBE = 2'h3, C_HOLD = 2'h2} fbp_cyc_t;
	typedef struct packed {
		logic wr;
		logic last;
		logic [24:0] a;
		logic [15:0] d;
	} fbp_step_t;
endpackage

/* rtl/fbp_delay.sv */
// one-shot delay of the unlock guard time
// assumes load_in is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
module fbp_delay (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// control
	input wire logic load_in,
	output logic busy_out
);
	import fbp_pkg::*;
	typedef struct packed {
		logic [7:0] cnt;
		logic busy;
	} fbp_dly_t;
	fbp_dly_t st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		if (load_in) begin
			st_next.cnt = 8'(UNLOCK_CYC - 1);
			st_next.busy = 1'b1;
		end else if (st_reg.cnt != 8'h00) begin
			st_next.cnt = st_reg.cnt - 8'h01;
		end else begin
			st_next.busy = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy_out = st_reg.busy;
endmodule

/* rtl/fbp_bus_cycle.sv */
// one asynchronous flash bus cycle, write or read, with timed strobes
// assumes start_in is a pulse given only while idle; request inputs stand with it
`timescale 1ns/1ps
module fbp_bus_cycle (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// request
	input wire logic start_in,
	input wire logic wr_in,
	input wire logic byte_mode_in,
	input wire logic [24:0] a_in,
	input wire logic [15:0] d_in,
	output logic done_out,
	output logic [15:0] rdata_out,
	// flash pins
	output logic [23:0] addr_out,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe_out,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out
);
	import fbp_pkg::*;
	// in x8 mode dq15 carries the lowest address bit, so it is driven on reads too
	localparam logic [15:0] OE_X8_W = 16'h80ff, OE_X8_R = 16'h8000, OE_X16_W = 16'hffff;
	typedef struct packed {
		fbp_cyc_t st;
		logic [3:0] cnt;
		logic wr;
		logic [23:0] addr;
		logic [15:0] dq;
		logic [15:0] oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic done;
		logic [15:0] rdata;
	} fbp_bc_t;
	fbp_bc_t st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		case (st_reg.st)
			C_IDLE: begin
				if (start_in) begin
					st_next.st = C_SETUP;
					st_next.cnt = 4'(AS_CYC - 1);
					st_next.wr = wr_in;
					st_next.addr = byte_mode_in ? a_in[24:1] : a_in[23:0];
					st_next.dq = byte_mode_in ? {a_in[0], 7'h00, d_in[7:0]} : d_in;
					st_next.oe = byte_mode_in ? (wr_in ? OE_X8_W : OE_X8_R) :
						(wr_in ? OE_X16_W : 16'h0000);
					st_next.ce_n = 1'b0;
				end
			end
			C_SETUP: begin
				if (st_reg.cnt != 4'h0) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					st_next.st = C_STROBE;
					st_next.cnt = st_reg.wr ? 4'(WP_CYC - 1) : 4'(ACC_CYC - 1);
					st_next.we_n = !st_reg.wr;
					st_next.oe_n = st_reg.wr;
				end
			end
			C_STROBE: begin
				if (st_reg.cnt != 4'h0) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					if (!st_reg.wr) begin
						st_next.rdata = dq_in;
					end
					st_next.st = C_HOLD;
					st_next.cnt = 4'(REC_CYC - 1);
					st_next.we_n = 1'b1;
					st_next.oe_n = 1'b1;
				end
			end
			C_HOLD: begin
				if (st_reg.cnt != 4'h0) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					st_next.st = C_IDLE;
					st_next.ce_n = 1'b1;
					st_next.oe = 16'h0000;
					st_next.done = 1'b1;
				end
			end
			default: begin
				st_next.st = C_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
			st_reg.ce_n <= 1'b1;
			st_reg.oe_n <= 1'b1;
			st_reg.we_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign done_out = st_reg.done;
	assign rdata_out = st_reg.rdata;
	assign addr_out = st_reg.addr;
	assign dq_out = st_reg.dq;
	assign dq_oe_out = st_reg.oe;
	assign ce_n_out = st_reg.ce_n;
	assign oe_n_out = st_reg.oe_n;
	assign we_n_out = st_reg.we_n;
endmodule

/* sim/fbp_flash_model.sv */
// behavioural flash: command-set tracking, password store, volatile bits
// assumes the pins of fbp_host; dq has no pull, so released data is inverted
`timescale 1ns/1ps
module fbp_flash_model (
	// host pins
	input wire logic [23:0] addr_in,
	input wire logic [15:0] dq_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic byte_n_in,
	// data back to host
	output logic [15:0] dq_out
);
	logic [63:0] pwd = '1;
	logic [255:0] vpb = '1;
	logic [255:0] nvpb = '1;
	// global lock of the nonvolatile bits: 1 = bits may change
	logic glock = 1'b1;
	logic unl = 1'b0;
	logic [63:0] upw = '1;
	logic [7:0] mode = 8'h00;
	logic [7:0] p1 = 8'h00;
	logic [7:0] p2 = 8'h00;
	logic [15:0] last = 16'h0000;
	logic [15:0] val;
	logic [2:0] k;
	// x8 position takes the byte-mode low address line as its lsb
	assign k = byte_n_in ? {1'b0, addr_in[1:0]} : {addr_in[1:0], dq_in[15]};
	always @(posedge we_n_in) begin
		if (p2 == 8'haa && p1 == 8'h55) begin
			mode = dq_in[7:0];
		end else if (p1 == 8'h90 && dq_in[7:0] == 8'h00) begin
			mode = 8'h00;
		end else if (mode == 8'h60 && p1 == 8'h25 && dq_in[7:0] == 8'h03) begin
			unl = 1'b1;
		end else if (unl && dq_in[7:0] == 8'h29) begin
			unl = 1'b0;
			if (upw == pwd) glock = 1'b1;
		end else if (unl) begin
			if (byte_n_in) upw[16*k[1:0] +: 16] = dq_in;
			else upw[8*k +: 8] = dq_in[7:0];
		end else if (p1 == 8'ha0 && mode == 8'h50) begin
			glock = 1'b0;
		end else if (p1 == 8'ha0 && mode == 8'hc0) begin
			if (glock) nvpb[addr_in[23:16]] = 1'b0;
		end else if (p1 == 8'h80 && dq_in[7:0] == 8'h30 && mode == 8'hc0) begin
			// programming all bits first ends in the same all-ones state
			if (glock) nvpb = '1;
		end else if (p1 == 8'ha0 && mode == 8'h60) begin
			if (byte_n_in) pwd[16*k[1:0] +: 16] = dq_in;
			else pwd[8*k +: 8] = dq_in[7:0];
		end else if (p1 == 8'ha0 && mode == 8'he0) begin
			vpb[addr_in[23:16]] = dq_in[0];
		end
		p2 = p1;
		p1 = dq_in[7:0];
	end
	always_comb begin
		if (mode == 8'h60) val = byte_n_in ? pwd[16*k[1:0] +: 16] : {8'h00, pwd[8*k +: 8]};
		else if (mode == 8'hc0) val = {15'h0000, nvpb[addr_in[23:16]]};
		else if (mode == 8'h50) val = {15'h0000, glock};
		else val = {15'h0000, vpb[addr_in[23:16]]};
		dq_out = (!ce_n_in && !oe_n_in) ? val : ~last;
	end
	always @(posedge oe_n_in) last = val;
endmodule

/* sim/flash_block_protection_cmds_bench.sv */
// self-checking bench of fbp_host against the behavioural flash
// assumes one 100 MHz clock; register port driven on rising edges
`timescale 1ns/1ps
module flash_block_protection_cmds_bench;
	import fbp_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic [31:0] reg_rdata_out, got;
	logic [23:0] fa;
	logic [15:0] h_dq, h_oe, f_dq, dq;
	logic ce_n, oe_n, we_n, byte_n;
	int miscompares = 0;
	int n_tests = 0;
	time t0;
	assign dq = (h_oe & h_dq) | (~h_oe & f_dq);
	fbp_host u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .flash_addr_out(fa), .flash_dq_in(dq),
		.flash_dq_out(h_dq), .flash_dq_oe_out(h_oe), .flash_ce_n_out(ce_n),
		.flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_byte_n_out(byte_n));
	fbp_flash_model u_flash (.addr_in(fa), .dq_in(dq), .ce_n_in(ce_n), .oe_n_in(oe_n),
		.we_n_in(we_n), .byte_n_in(byte_n), .dq_out(f_dq));
	initial forever #5 mclk_in = ~mclk_in;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 got = reg_rdata_out;
	endtask
	// busy is polled with a bound so a stuck sequencer cannot hang the run
	task automatic cmd(input logic [3:0] op, input logic [7:0] code);
		wr(REG_CMD, {20'h0, code, op});
		for (int i = 0; i < 600; i++) begin
			rd(REG_STATUS);
			if (got[ST_BUSY] === 1'b0) return;
		end
		check(got, 32'h0);
	endtask
	task automatic pw_roundtrip;
		wr(REG_CFG, 32'h1);
		wr(REG_PWD_LO, 32'h89abcdef);
		wr(REG_PWD_HI, 32'h01234567);
		cmd(OP_ENTER, CODE_PASSWORD);
		check({29'h0, got[6:4]}, 32'h2);
		check({31'h0, byte_n}, 32'h0);
		cmd(OP_PW_PROG, 8'h00);
		cmd(OP_PW_READ, 8'h00);
		rd(REG_PWRD_LO);
		check(got, 32'h89abcdef);
		rd(REG_PWRD_HI);
		check(got, 32'h01234567);
		t0 = $time;
		cmd(OP_UNLOCK, 8'h00);
		check({31'h0, ($time - t0) >= 2210}, 32'h1);
	endtask
	task automatic refuse;
		cmd(OP_CLR_NV, 8'h00);
		check({31'h0, got[ST_ERR]}, 32'h1);
		wr(REG_STATUS, 32'h2);
		rd(REG_STATUS);
		check({31'h0, got[ST_ERR]}, 32'h0);
	endtask
	task automatic vpb_cycle;
		cmd(OP_EXIT_PROT, 8'h00);
		cmd(OP_ENTER, CODE_VPB);
		wr(REG_ADDR, 32'h0060000);
		for (int v = 0; v < 2; v++) begin
			wr(REG_WDATA, v);
			cmd(OP_PROG, 8'h00);
			cmd(OP_READ, 8'h00);
			check({31'h0, got[ST_PROT]}, {31'h0, v == 0});
			rd(REG_RDATA);
			check(got, v);
		end
	endtask
	task automatic prot_read(input logic exp);
		cmd(OP_READ, 8'h00);
		check({31'h0, got[ST_PROT]}, {31'h0, exp});
	endtask
	task automatic set_mode(input logic [3:0] op, input logic [7:0] code);
		cmd(OP_EXIT_PROT, 8'h00);
		cmd(op, code);
	endtask
	task automatic nv_cycle;
		set_mode(OP_ENTER, CODE_NVPB);
		wr(REG_WDATA, 32'h0);
		cmd(OP_PROG, 8'h00);
		prot_read(1'b1);
		set_mode(OP_ENTER, CODE_LOCKBIT);
		cmd(OP_PROG, 8'h00);
		prot_read(1'b1);
		set_mode(OP_ENTER, CODE_NVPB);
		cmd(OP_CLR_NV, 8'h00);
		prot_read(1'b1);
		set_mode(OP_ENTER, CODE_PASSWORD);
		cmd(OP_UNLOCK, 8'h00);
		set_mode(OP_ENTER, CODE_NVPB);
		cmd(OP_CLR_NV, 8'h00);
		prot_read(1'b0);
		set_mode(OP_ENTER, CODE_EXT);
		check({29'h0, got[6:4]}, 32'h6);
		cmd(OP_EXIT_EXT, 8'h00);
		check({29'h0, got[6:4]}, 32'h0);
		cmd(OP_ENTER, CODE_LOCKREG);
		check({29'h0, got[6:4]}, 32'h1);
		cmd(OP_EXIT_PROT, 8'h00);
		check({29'h0, got[6:4]}, 32'h0);
	endtask
	task automatic results;
		if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		results();
	end
	initial begin
		repeat (6) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		rd(REG_PWD_HI);
		check(got, 32'hffffffff);
		rd(8'h3c);
		check(got, 32'h0);
		pw_roundtrip();
		refuse();
		vpb_cycle();
		nv_cycle();
		results();
	end
endmodule
